// >>> core/thr_regs.vh
`ifndef THR_REGS_VH
`define THR_REGS_VH

// register addresses on the plain port
`define THR_ADDR_CTRL     4'h0
`define THR_ADDR_STAT     4'h4

// system clock and input sampling
`define THR_CLK_MHZ       250
`define THR_SAMP_NS       50
`define THR_DIV_RST       ((`THR_SAMP_NS*`THR_CLK_MHZ)/1000)
`define THR_TICKS_PER_BIT 8
`define THR_BIT_NS        400

// end of data silence, in sample ticks
`define THR_EOD_NS        5600
`define THR_EOD_TICKS     ((`THR_EOD_NS*`THR_TICKS_PER_BIT)/`THR_BIT_NS)

// extra latency of the repeat path
`define THR_BJ_NS         400
`define THR_BJ_TICKS      ((`THR_BJ_NS*`THR_TICKS_PER_BIT)/`THR_BIT_NS)
`define THR_POL_NS        200
`define THR_POL_TICKS     ((`THR_POL_NS*`THR_TICKS_PER_BIT)/`THR_BIT_NS)

// dead band half width and output pulse length, in ticks
`define THR_DB_TICKS      2
`define THR_PULSE_TICKS   4

// status field positions
`define THR_STAT_RUN      0
`define THR_STAT_SEL_LSB  1
`define THR_STAT_REF      4

`endif

// >>> core/thr_repeater.v
`timescale 1ns/10ps
`default_nettype none
`include "thr_regs.vh"
module thr_repeater
(
   input  wire       clk_sys,
   input  wire       rst_b,
   input  wire [3:0] port_rx_input,
   input  wire       extension_rx_in,
   input  wire       group_a_rx_polarity_sel,
   input  wire       group_b_rx_polarity_sel,
   input  wire       ext_rx_polarity_sel,
   input  wire       group_a_big_jitter_sel_n,
   input  wire       group_b_big_jitter_sel_n,
   input  wire       ext_big_jitter_sel_n,
   input  wire       group_a_noise_cut_sel_n,
   input  wire       group_b_noise_cut_sel_n,
   input  wire       ext_noise_cut_sel_n,
   input  wire       group_a_tx_ctrl_sel,
   input  wire       group_b_tx_ctrl_sel,
   input  wire       ext_tx_ctrl_sel,
   input  wire       test_clock_out_enable_n,
   input  wire [3:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   output wire       dipulse_out_first_n,
   output wire       dipulse_out_second_n,
   output wire       backplane_pulse_out_n,
   output wire [1:0] group_a_tx_enable,
   output wire [1:0] group_b_tx_enable,
   output wire       extension_tx_out,
   output reg        test_clock_out
);

   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_RUN  = 2'b10;

   // port index to group: 0,1 a; 2,3 b; 4 extension
   function [1:0] thr_grp;
      input [2:0] p;
      begin
         if (p < 3'd2)
            thr_grp = 2'd0;
         else if (p < 3'd4)
            thr_grp = 2'd1;
         else
            thr_grp = 2'd2;
      end
   endfunction

   function [2:0] thr_first;
      input [4:0] v;
      integer k;
      begin
         thr_first = 3'd0;
         for (k = 4; k >= 0; k = k - 1)
            if (v[k])
               thr_first = k[2:0];
      end
   endfunction

   wire [31:0] div_rst_w = `THR_DIV_RST;
   wire [31:0] eod_w     = `THR_EOD_TICKS;
   wire [31:0] bj_w      = `THR_BJ_TICKS;
   wire [31:0] pol_w     = `THR_POL_TICKS;
   wire [31:0] db_w      = `THR_DB_TICKS;
   wire [31:0] pls_w     = `THR_PULSE_TICKS;

   // straps and receive pins, two flops before use
   wire [17:0] pins_w = {ext_tx_ctrl_sel, group_b_tx_ctrl_sel,
                         group_a_tx_ctrl_sel, ext_noise_cut_sel_n,
                         group_b_noise_cut_sel_n,
                         group_a_noise_cut_sel_n, ext_big_jitter_sel_n,
                         group_b_big_jitter_sel_n,
                         group_a_big_jitter_sel_n, ext_rx_polarity_sel,
                         group_b_rx_polarity_sel,
                         group_a_rx_polarity_sel,
                         test_clock_out_enable_n, extension_rx_in,
                         port_rx_input};
   reg  [17:0] pin_s1_r;
   reg  [17:0] pin_s2_r;

   always @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         pin_s1_r <= 18'h3ffff;
         pin_s2_r <= 18'h3ffff;
      end
      else
      begin
         pin_s1_r <= pins_w;
         pin_s2_r <= pin_s1_r;
      end
   end

   wire [4:0] rx_w  = pin_s2_r[4:0];
   wire       ckn_w = pin_s2_r[5];
   wire [2:0] pol_v = pin_s2_r[8:6];
   wire [2:0] nbj_v = pin_s2_r[11:9];
   wire [2:0] nmb_v = pin_s2_r[14:12];
   wire [2:0] txc_v = pin_s2_r[17:15];

   reg  [1:0]  st_r;
   reg  [2:0]  sel_r;
   reg  [7:0]  div_r;
   reg  [7:0]  tcnt_r;
   reg         tick_r;
   reg         smp_r;
   reg         smp_d_r;
   reg  [7:0]  quiet_r;
   reg  [2:0]  ph_r;
   reg         ref_r;
   reg         seen_r;
   reg         hit_r;
   reg  [2:0]  hist_r;
   reg  [2:0]  gen_r;
   reg  [38:0] dl_r;
   reg         p1_n_r;
   reg         p2_n_r;
   reg         bp_n_r;
   reg  [4:0]  ten_r;

   // per port activity after polarity, per group selects
   wire [4:0] act_w;
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi = gi + 1)
      begin : g_act
         localparam [2:0] PI = gi;
         assign act_w[gi] = rx_w[gi] ^ pol_v[thr_grp(PI)];
      end
   endgenerate

   wire       run_w   = st_r[1];
   wire [1:0] gsel_w  = thr_grp(sel_r);
   wire       pol_sel = pol_v[gsel_w];
   wire       nbj_sel = nbj_v[gsel_w];
   wire       nmb_sel = nmb_v[gsel_w];

   // sample tick, eight per bit; divider sets the data rate
   wire [8:0] tnext_w = {1'b0, tcnt_r} + 9'd1;

   always @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         tcnt_r <= 8'h00;
         tick_r <= 1'b0;
      end
      else if (tnext_w >= {1'b0, div_r})
      begin
         tcnt_r <= 8'h00;
         tick_r <= 1'b1;
      end
      else
      begin
         tcnt_r <= tnext_w[7:0];
         tick_r <= 1'b0;
      end
   end

   // edge detection on the locked port only
   wire       edge_w = tick_r & smp_r & ~smp_d_r;
   wire [2:0] db3_w  = db_w[2:0];
   wire       win_w  = (ph_r <= db3_w) | (ph_r >= (3'd0 - db3_w));
   // dead band: stray edges from ringing are simply dropped
   wire       acc_w  = edge_w & (~ref_r | nmb_sel | win_w);
   wire       bit_w  = hit_r | acc_w;
   wire       close_w = tick_r & (ph_r == 3'd3);
   wire       eod_w2 = (quiet_r == eod_w[7:0]);

   always @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         st_r    <= ST_IDLE;
         sel_r   <= 3'd0;
         smp_r   <= 1'b0;
         smp_d_r <= 1'b0;
         quiet_r <= 8'h00;
         ph_r    <= 3'd0;
         ref_r   <= 1'b0;
         seen_r  <= 1'b0;
         hit_r   <= 1'b0;
         hist_r  <= 3'd0;
      end
      else
      begin
         case (st_r)
            ST_IDLE:
            begin
               smp_r   <= 1'b0;
               smp_d_r <= 1'b0;
               quiet_r <= 8'h00;
               ref_r   <= 1'b0;
               seen_r  <= 1'b0;
               hit_r   <= 1'b0;
               hist_r  <= 3'd0;
               ph_r    <= 3'd0;
               if (|act_w)
               begin
                  sel_r <= thr_first(act_w);
                  st_r  <= ST_RUN;
               end
            end
            ST_RUN:
            begin
               if (tick_r)
               begin
                  smp_r   <= act_w[sel_r];
                  smp_d_r <= smp_r;
                  // activity from alert and lead-ins keeps the hold
                  if (smp_r)
                     quiet_r <= 8'h00;
                  else if (!eod_w2)
                     quiet_r <= quiet_r + 8'h01;
                  if (acc_w && !ref_r)
                  begin
                     // anchor, final on 1st pulse; provisional until 2nd with big jitter selected
                     ph_r   <= 3'd1;
                     seen_r <= 1'b1;
                     ref_r  <= nbj_sel | seen_r;
                  end
                  else if (acc_w && hist_r == 3'b110)
                     ph_r <= 3'd1;
                  else if (acc_w && ph_r >= 3'd1 && ph_r <= 3'd3)
                     ph_r <= ph_r;
                  else if (acc_w && ph_r >= 3'd4)
                     ph_r <= ph_r + 3'd2;
                  else
                     ph_r <= ph_r + 3'd1;
                  if (close_w)
                  begin
                     hist_r <= {hist_r[1:0], bit_w};
                     hit_r  <= 1'b0;
                  end
                  else if (acc_w)
                     hit_r <= 1'b1;
               end
               if (eod_w2)
                  st_r <= ST_IDLE;
            end
            default:
               st_r <= ST_IDLE;
         endcase
      end
   end

   // pulse shaping, half a bit long, split for the dipulse pair
   wire [2:0] wave_w = {gen_r != 3'd0,
                        (gen_r != 3'd0) & (gen_r <= 3'd2),
                        gen_r > 3'd2};
   wire [3:0] tap_w  = (nbj_sel ? 4'd0 : bj_w[3:0]) +
                       (pol_sel ? pol_w[3:0] : 4'd0);
   wire [5:0] tap3_w = {1'b0, tap_w, 1'b0} + {2'b00, tap_w};
   wire [2:0] out_w  = dl_r[tap3_w +: 3];

   always @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         gen_r <= 3'd0;
         dl_r  <= 39'h0;
      end
      else if (!run_w)
      begin
         gen_r <= 3'd0;
         dl_r  <= 39'h0;
      end
      else if (tick_r)
      begin
         if (close_w && bit_w)
            gen_r <= pls_w[2:0];
         else if (gen_r != 3'd0)
            gen_r <= gen_r - 3'd1;
         // fixed tap line: latency added by mode, not by fill level
         dl_r <= {dl_r[35:0], wave_w};
      end
   end

   // transmit side, all ports but the receiving one
   wire [4:0] tx_w;
   generate
      for (gi = 0; gi < 5; gi = gi + 1)
      begin : g_tx
         localparam [2:0] PT = gi;
         wire on_w = run_w & (sel_r != PT);
         assign tx_w[gi] = txc_v[thr_grp(PT)] ? on_w :
                           (on_w & out_w[2]);
      end
   endgenerate

   always @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         p1_n_r <= 1'b1;
         p2_n_r <= 1'b1;
         bp_n_r <= 1'b1;
         ten_r  <= 5'h00;
      end
      else
      begin
         p1_n_r <= ~(run_w & out_w[0]);
         p2_n_r <= ~(run_w & out_w[1]);
         bp_n_r <= ~(run_w & out_w[2]);
         ten_r  <= tx_w;
      end
   end

   assign dipulse_out_first_n   = p1_n_r;
   assign dipulse_out_second_n  = p2_n_r;
   assign backplane_pulse_out_n = bp_n_r;
   assign group_a_tx_enable     = ten_r[1:0];
   assign group_b_tx_enable     = ten_r[3:2];
   assign extension_tx_out      = ten_r[4];

   // test clock is half of clk_sys, so it comes from a flop
   always @(posedge clk_sys)
   begin
      if (!rst_b)
         test_clock_out <= 1'b0;
      else if (ckn_w)
         test_clock_out <= 1'b0;
      else
         test_clock_out <= ~test_clock_out;
   end

   // register port
   always @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         div_r     <= div_rst_w[7:0];
         reg_rdata <= 8'h00;
      end
      else
      begin
         if (reg_wr && reg_addr == `THR_ADDR_CTRL)
            div_r <= reg_wdata;
         if (reg_rd && reg_addr == `THR_ADDR_CTRL)
            reg_rdata <= div_r;
         else if (reg_rd && reg_addr == `THR_ADDR_STAT)
            reg_rdata <= {3'b000, ref_r, sel_r, run_w};
         else
            reg_rdata <= 8'h00;
      end
   end

endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "thr_regs.vh"
module tb_top;
   logic        clk_sys = 1'b0;
   logic        rst_b = 1'b0;
   logic [11:0] cfg = 12'hfff;
   logic        tck_n = 1'b1;
   logic [3:0]  reg_addr = 4'h0;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        go = 1'b0;
   logic [7:0]  data = 8'h00;
   logic [4:0]  sel_m = 5'h00;
   logic        inv = 1'b0;
   logic        jit = 1'b0;
   wire logic   line_n, busy, pin, te, p1, p2, bp, tco;
   wire logic [4:0] rx, ten;
   wire logic [7:0] rdat;
   wire logic [1:0] ta, tb;
   int n_mismatch = 0, check_count = 0, cyc = 0;
   int n_pul, n_bp, n_gb, n_tog, t_in, t_out, t_rise;
   int lat [9];
   // unselected pins idle at the inactive level of their group
   assign pin = inv ^ line_n;
   assign rx = sel_m & {5{pin}} | ~sel_m & {3'h7, cfg[0], cfg[0]};
   assign ten = {te, tb, ta};
   initial forever #2 clk_sys = ~clk_sys;
   thr_node_model node (.clk_sys(clk_sys), .go(go), .jit(jit), .data(data),
      .line_n(line_n), .busy(busy));
   thr_repeater dut (.clk_sys(clk_sys), .rst_b(rst_b),
      .port_rx_input(rx[3:0]), .extension_rx_in(rx[4]),
      .group_a_rx_polarity_sel(cfg[0]), .group_b_rx_polarity_sel(cfg[1]),
      .ext_rx_polarity_sel(cfg[2]), .group_a_big_jitter_sel_n(cfg[3]),
      .group_b_big_jitter_sel_n(cfg[4]), .ext_big_jitter_sel_n(cfg[5]),
      .group_a_noise_cut_sel_n(cfg[6]), .group_b_noise_cut_sel_n(cfg[7]),
      .ext_noise_cut_sel_n(cfg[8]), .group_a_tx_ctrl_sel(cfg[9]),
      .group_b_tx_ctrl_sel(cfg[10]), .ext_tx_ctrl_sel(cfg[11]),
      .test_clock_out_enable_n(tck_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(rdat), .dipulse_out_first_n(p1),
      .dipulse_out_second_n(p2), .backplane_pulse_out_n(bp),
      .group_a_tx_enable(ta), .group_b_tx_enable(tb),
      .extension_tx_out(te), .test_clock_out(tco));
   always @(negedge bp)
   begin
      n_pul++;
      t_out = $time;
   end
   always @(negedge line_n) t_in = $time;
   always @(posedge line_n) t_rise = $time;
   always @(tco) n_tog++;
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (!bp) n_bp++;
      if (tb[0]) n_gb++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         summarize();
      end
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e)
      begin
         $display("mismatch t=%0t got %h exp %h", $time, g, e);
         n_mismatch++;
      end
   endtask
   task automatic tick;
      @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] m, e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(16'(rdat & m), 16'(e));
   endtask
   task automatic run(input int r);
      int s, w;
      logic [11:0] m;
      s = (r < 5) ? r : (r == 8) ? 4 : 0;
      m = (r == 5) ? 12'h8 : (r == 6) ? 12'h1 : (r == 7) ? 12'h40 :
          (r == 8) ? 12'h400 : 12'h0;
      @(posedge clk_sys);
      cfg <= ~m;
      inv <= (r == 6);
      jit <= (r == 3);
      data <= 8'(r * 29);
      sel_m <= 5'(1 << s);
      repeat (4) @(posedge clk_sys);
      n_pul = 0;
      n_bp = 0;
      n_gb = 0;
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      for (w = 0; ten === 5'h00 && w < 100; w++) tick;
      tick;
      if (r != 8) chk(16'(ten), 16'(5'h1f & ~(5'h1 << s)));
      rd(`THR_ADDR_STAT, 8'h0f, 8'(s * 2 + 1));
      @(posedge clk_sys);
      sel_m <= sel_m | 5'(1 << ((s + 1) % 5));
      for (w = 0; busy && w < 300; w++) tick;
      for (w = 0; ten !== 5'h00 && w < 400; w++) tick;
      w = ($time - t_rise) / 4;
      chk(16'(w > 107 && w < 125), 16'h1);
      chk(16'(n_pul), 16'(8 + $countones(data)));
      lat[r] = (t_out - t_in) / 4;
      if (r == 5) chk(16'(lat[5] - lat[0]), `THR_BJ_TICKS);
      // polarity sel 1 is the inverted, slower setting of the baseline
      if (r == 6) chk(16'(lat[0] - lat[6]), `THR_POL_TICKS);
      if (r == 8) chk(16'(n_gb), 16'(n_bp));
      repeat (260) @(posedge clk_sys);
      $display("test %0d done", r);
   endtask
   initial
   begin
      repeat (4) tick;
      chk(16'({ten, p1, bp, tco}), 16'h06);
      @(posedge clk_sys);
      rst_b <= 1'b1;
      wr(`THR_ADDR_CTRL, 8'h01);
      rd(`THR_ADDR_CTRL, 8'hff, 8'h01);
      rd(4'h8, 8'hff, 8'h00);
      rd(`THR_ADDR_STAT, 8'h01, 8'h00);
      $display("test regs done");
      for (int r = 0; r < 9; r++) run(r);
      @(posedge clk_sys);
      tck_n <= 1'b0;
      repeat (4) tick;
      n_tog = 0;
      repeat (20) tick;
      chk(16'(n_tog), 16'd20);
      @(posedge clk_sys);
      tck_n <= 1'b1;
      repeat (4) tick;
      chk(16'(tco), 16'h0);
      $display("test clock done");
      summarize();
   end
endmodule
`default_nettype wire

// >>> tb/thr_node_model.sv
`timescale 1ns/10ps
`default_nettype none
module thr_node_model
(
   input  wire logic       clk_sys,
   input  wire logic       go,
   input  wire logic       jit,
   input  wire logic [7:0] data,
   output var  logic       line_n,
   output var  logic       busy
);
   logic [16:0] bits;
   integer      i;
   integer      k;
   integer      d;
   // one bit is 8 clocks: divider 1 gives a tick per clock
   // jitter: pulses start up to 2 ticks late, inside pll tolerance
   initial
   begin
      line_n = 1'b1;
      busy = 1'b0;
      forever
      begin
         @(posedge clk_sys);
         if (go)
         begin
            busy <= 1'b1;
            bits = {6'h3f, 3'h6, data};
            for (i = 16; i >= 0; i--)
            begin
               d = jit ? i % 3 : 0;
               for (k = 0; k < 8; k++)
               begin
                  line_n <= !(bits[i] && k >= d && k < d + 4);
                  @(posedge clk_sys);
               end
            end
            line_n <= 1'b1;
            busy <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// >>> tb/thr_repeater_sva.sv
`timescale 1ns/10ps
`default_nettype none
module thr_repeater_chk
(
   input wire logic       clk_sys,
   input wire logic       rst_b,
   input wire logic       group_a_tx_ctrl_sel,
   input wire logic       group_b_tx_ctrl_sel,
   input wire logic       ext_tx_ctrl_sel,
   input wire logic       test_clock_out_enable_n,
   input wire logic       dipulse_out_first_n,
   input wire logic       dipulse_out_second_n,
   input wire logic       backplane_pulse_out_n,
   input wire logic [1:0] group_a_tx_enable,
   input wire logic [1:0] group_b_tx_enable,
   input wire logic       extension_tx_out,
   input wire logic       test_clock_out
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   wire logic [4:0] ten;
   wire logic       lvl;
   logic [7:0]      quiet_r;
   assign ten = {extension_tx_out, group_b_tx_enable, group_a_tx_enable};
   assign lvl = group_a_tx_ctrl_sel & group_b_tx_ctrl_sel & ext_tx_ctrl_sel;
   // output silence since last pulse; pulses lag input by the taps, release does not
   always @(posedge clk_sys)
      if (!rst_b || !backplane_pulse_out_n)
         quiet_r <= 8'h00;
      else if (quiet_r != 8'hff)
         quiet_r <= quiet_r + 8'h01;
   property p_idle; $rose(rst_b) |-> ten == 0 && backplane_pulse_out_n
      && dipulse_out_first_n && !test_clock_out; endproperty
   property p_one; lvl && ten != 0 |-> $countones(ten) == 4; endproperty
   property p_hold; lvl && $past(ten) != 0 && ten != 0 |-> $stable(ten);
   endproperty
   property p_pair; $fell(dipulse_out_first_n) |->
      ##[1:30] $fell(dipulse_out_second_n); endproperty
   property p_run; lvl && !backplane_pulse_out_n |-> ten != 0; endproperty
   property p_eod; $past(ten) != 0 && ten == 0 |-> quiet_r >= 8'h40;
   endproperty
   property p_tlow; test_clock_out_enable_n [*4] |-> !test_clock_out;
   endproperty
   property p_trun; !test_clock_out_enable_n [*5] |->
      test_clock_out != $past(test_clock_out); endproperty
   a_idle: assert property (p_idle) else $error("not idle");
   a_one: assert property (p_one) else $error("rx count");
   a_hold: assert property (p_hold) else $error("dir moved");
   a_pair: assert property (p_pair) else $error("no 2nd half");
   a_run: assert property (p_run) else $error("pulse idle");
   a_eod: assert property (p_eod) else $error("early end");
   a_tlow: assert property (p_tlow) else $error("clk out");
   a_trun: assert property (p_trun) else $error("clk stuck");
   c_msg: cover property ($fell(backplane_pulse_out_n));
   c_end: cover property ($past(ten) != 0 && ten == 0);
   c_dat: cover property (!lvl && ten != 0);
endmodule
bind thr_repeater thr_repeater_chk u_chk
(
   .clk_sys                 (clk_sys),
   .rst_b                   (rst_b),
   .group_a_tx_ctrl_sel     (group_a_tx_ctrl_sel),
   .group_b_tx_ctrl_sel     (group_b_tx_ctrl_sel),
   .ext_tx_ctrl_sel         (ext_tx_ctrl_sel),
   .test_clock_out_enable_n (test_clock_out_enable_n),
   .dipulse_out_first_n     (dipulse_out_first_n),
   .dipulse_out_second_n    (dipulse_out_second_n),
   .backplane_pulse_out_n   (backplane_pulse_out_n),
   .group_a_tx_enable       (group_a_tx_enable),
   .group_b_tx_enable       (group_b_tx_enable),
   .extension_tx_out        (extension_tx_out),
   .test_clock_out          (test_clock_out)
);
`default_nettype wire
